// file: bit_manipulation_instr_exec.sv
// Decode and execute of bit clear, bit set and bit test-skip-if-clear
`timescale 1ns/1ps
module bit_manipulation_instr_exec #(
  parameter int NUM_REGS = 32
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire bit_exec_pkg::instr_type instr_i,
  output bit_exec_pkg::reg_write_type reg_wr_o,
  output logic discard_o,
  output logic nop_o,
  output logic done_o,
  output logic status_we_o
);
  import bit_exec_pkg::*;

  initial begin
    if (NUM_REGS < 1 || NUM_REGS > REG_COUNT) $error("NUM_REGS out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic logic [3:0] opcode_of(input logic [INSTR_WIDTH-1:0] w);
    opcode_of = w[OPCODE_MSB:OPCODE_LSB];
  endfunction : opcode_of

  wire [3:0] op = opcode_of(instr_i.word);
  wire [ADDR_WIDTH-1:0] addr = instr_i.word[ADDR_MSB:ADDR_LSB];
  wire [BIT_IDX_WIDTH-1:0] bidx = instr_i.word[BIT_IDX_MSB:BIT_IDX_LSB];
  wire is_clr = instr_i.valid && (op == BIT_CLEAR_OPCODE);
  wire is_set = instr_i.valid && (op == BIT_SET_OPCODE);
  wire is_tst = instr_i.valid && (op == BIT_TEST_SKIP_OPCODE);

  ////////////////////////////////////////////////////////////////////////
  // Execute stage: hold operands while the register file is read
  stage_type stage_q;
  stage_type stage_d;
  logic [ADDR_WIDTH-1:0] addr_q;
  logic [BIT_IDX_WIDTH-1:0] bidx_q;
  logic set_val_q;
  logic skip_q;
  logic [DATA_WIDTH-1:0] rd_data;

  // A slot that follows a taken skip is the discarded prefetch
  wire accept = !skip_q;

  always_comb begin
    stage_d = OP_NONE;
    if (accept && (is_clr || is_set)) begin
      stage_d = OP_WRITE;
    end else if (accept && is_tst) begin
      stage_d = OP_SKIP;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      stage_q <= OP_NONE;
      addr_q <= '0;
      bidx_q <= '0;
      set_val_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      addr_q <= addr;
      bidx_q <= bidx;
      set_val_q <= is_set;
    end
  end

  bit_reg_file #(
    .DEPTH(NUM_REGS),
    .WIDTH(DATA_WIDTH),
    .AW(ADDR_WIDTH)
  ) u_regs (
    .core_clk_i(core_clk_i),
    .rd_addr_i(addr),
    .rd_data_o(rd_data),
    .wr_en_i(reg_wr_o.en),
    .wr_addr_i(reg_wr_o.addr),
    .wr_data_i(reg_wr_o.data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Write-back and skip
  wire [DATA_WIDTH-1:0] bit_mask = DATA_WIDTH'(1) << bidx_q;
  wire [DATA_WIDTH-1:0] new_data = set_val_q ? (rd_data | bit_mask)
                                             : (rd_data & ~bit_mask);
  wire do_write = (stage_q == OP_WRITE);
  wire tested_bit = rd_data[bidx_q];
  wire do_skip = (stage_q == OP_SKIP) && !tested_bit;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      reg_wr_o <= '0;
      skip_q <= 1'b0;
      discard_o <= 1'b0;
      nop_o <= 1'b0;
      done_o <= 1'b0;
      status_we_o <= 1'b0;
    end else begin
      reg_wr_o.en <= do_write;
      reg_wr_o.addr <= addr_q;
      reg_wr_o.data <= new_data;
      skip_q <= do_skip;
      discard_o <= do_skip;
      nop_o <= skip_q;
      done_o <= do_write || (stage_q == OP_SKIP && tested_bit) || skip_q;
      status_we_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence clr_issue;
    is_clr && accept;
  endsequence
  sequence set_issue;
    is_set && accept;
  endsequence

  a_clear_write_back: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    clr_issue |-> ##2 (reg_wr_o.en && reg_wr_o.data[$past(bidx, 2)] == 1'b0))
    else $error("bit clear did not write a zero bit");
  a_set_write_back: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    set_issue |-> ##2 (reg_wr_o.en && reg_wr_o.data[$past(bidx, 2)] == 1'b1))
    else $error("bit set did not write a one bit");
  a_write_addr_kept: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (clr_issue or set_issue) |-> ##2 (reg_wr_o.addr == $past(addr, 2)))
    else $error("write address differs from instruction field");
  a_other_bits_kept: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    do_write |=> ((reg_wr_o.data | $past(bit_mask)) == ($past(rd_data) | $past(bit_mask))))
    else $error("unselected bits changed");
  a_flags_untouched: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !status_we_o)
    else $error("status flags written");
  a_skip_on_zero: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (stage_q == OP_SKIP && !tested_bit) |=> discard_o ##1 nop_o)
    else $error("skip not taken on zero bit");
  a_no_skip_on_one: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (stage_q == OP_SKIP && tested_bit) |=> (done_o && !discard_o) ##1 !nop_o)
    else $error("skip taken on one bit");
  a_prefetch_dropped: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    skip_q |=> (stage_q == OP_NONE) ##1 !reg_wr_o.en)
    else $error("discarded instruction was executed");
endmodule : bit_manipulation_instr_exec

// file: bit_exec_pkg.sv
// Shared constants and carrier types for the bit-oriented instruction executor
package bit_exec_pkg;
  localparam int INSTR_WIDTH = 12;
  localparam int DATA_WIDTH = 8;
  localparam int ADDR_WIDTH = 5;
  localparam int BIT_IDX_WIDTH = 3;
  localparam int OPCODE_MSB = 11;
  localparam int OPCODE_LSB = 8;
  localparam int BIT_IDX_MSB = 7;
  localparam int BIT_IDX_LSB = 5;
  localparam int ADDR_MSB = 4;
  localparam int ADDR_LSB = 0;
  localparam int REG_COUNT = 32;
  localparam logic [3:0] BIT_CLEAR_OPCODE = 4'h4;
  localparam logic [3:0] BIT_SET_OPCODE = 4'h5;
  localparam logic [3:0] BIT_TEST_SKIP_OPCODE = 4'h6;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int SKIP_CYCLES = 1;

  typedef enum logic [2:0] {
    OP_NONE = 3'b001,
    OP_WRITE = 3'b010,
    OP_SKIP = 3'b100
  } stage_type;

  typedef struct packed {
    logic valid;
    logic [INSTR_WIDTH-1:0] word;
  } instr_type;

  typedef struct packed {
    logic en;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] data;
  } reg_write_type;
endpackage : bit_exec_pkg

// file: bit_reg_file.sv
// Small 32 x 8 register file with registered read data
`timescale 1ns/1ps
module bit_reg_file #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 8,
  parameter int AW = 5
) (
  input wire logic core_clk_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i
);
  initial begin
    if (DEPTH > (1 << AW)) $error("bit_reg_file: DEPTH exceeds address range");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule : bit_reg_file

// file: fetch_model.sv
// Fetch pipeline model that presents instruction words to the executor
`timescale 1ns/1ps
module fetch_model (
  input wire logic core_clk_i,
  input wire logic valid_i,
  input wire logic [11:0] word_i,
  output bit_exec_pkg::instr_type instr_o
);
  import bit_exec_pkg::*;
  initial instr_o = '0;
  // Idle slots carry a changing word so a stale one is never taken for an instruction
  always @(posedge core_clk_i) begin
    instr_o.valid <= valid_i;
    instr_o.word <= valid_i ? word_i : ~instr_o.word;
  end
endmodule : fetch_model

// file: bit_manipulation_instr_exec_bench.sv
// Self-checking testbench for the bit-oriented instruction executor
`timescale 1ns/1ps
module bit_manipulation_instr_exec_bench;
  import bit_exec_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic nxt_valid = 1'b0;
  logic [11:0] nxt_word = 12'h000;
  instr_type instr;
  reg_write_type wr;
  logic disc, nop, done, swe;
  int errors = 0;
  int checked = 0;

  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  fetch_model fm (.core_clk_i(core_clk_i), .valid_i(nxt_valid), .word_i(nxt_word),
    .instr_o(instr));
  bit_manipulation_instr_exec uut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .instr_i(instr), .reg_wr_o(wr), .discard_o(disc), .nop_o(nop), .done_o(done),
    .status_we_o(swe));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // One instruction, then idle until its result is due
  task automatic issue(input logic [11:0] w);
    @(posedge core_clk_i);
    nxt_valid <= 1'b1;
    nxt_word <= w;
    @(posedge core_clk_i);
    nxt_valid <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : issue

  task automatic set_all_bits;
    for (int b = 0; b < 8; b++) begin
      issue({4'h5, b[2:0], 5'd5});
      cmp({done, disc, swe, wr.en, wr.addr, wr.data[b]}, {4'b1001, 5'd5, 1'b1});
    end
    cmp(wr.data, 8'hff);
  endtask : set_all_bits

  task automatic clear_top_bit;
    issue(12'h4e5);
    cmp({done, disc, swe, wr}, {3'b100, 1'b1, 5'd5, 8'h7f});
  endtask : clear_top_bit

  task automatic test_skip_taken;
    issue(12'h6e5);
    cmp({done, disc, swe, wr.en}, 4'b0100);
    @(posedge core_clk_i);
    #1;
    cmp({nop, done, disc}, 3'b110);
  endtask : test_skip_taken

  task automatic test_no_skip;
    issue(12'h605);
    cmp({done, disc, swe, wr.en}, 4'b1000);
    @(posedge core_clk_i);
    #1;
    cmp({nop, disc}, 2'b00);
  endtask : test_no_skip

  // A set placed in the slot dropped by a taken skip must not write
  task automatic skip_drops_prefetch;
    @(posedge core_clk_i);
    nxt_valid <= 1'b1;
    nxt_word <= 12'h6e5;
    @(posedge core_clk_i);
    nxt_valid <= 1'b0;
    @(posedge core_clk_i);
    nxt_valid <= 1'b1;
    nxt_word <= 12'h505;
    @(posedge core_clk_i);
    nxt_valid <= 1'b0;
    @(posedge core_clk_i);
    #1;
    cmp({nop, wr.en}, 2'b10);
    @(posedge core_clk_i);
    #1;
    cmp(wr.en, 1'b0);
  endtask : skip_drops_prefetch

  task automatic edge_cases;
    issue(12'h5ff);
    cmp({done, wr.en, wr.addr, wr.data[7]}, {2'b11, 5'd31, 1'b1});
    issue(12'h7e5);
    cmp({done, disc, swe, wr.en}, 4'b0000);
  endtask : edge_cases

  task automatic stop_test;
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (8) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    set_all_bits();
    clear_top_bit();
    test_skip_taken();
    test_no_skip();
    skip_drops_prefetch();
    edge_cases();
    stop_test();
  end
endmodule : bit_manipulation_instr_exec_bench
